// ===== hdl/pllcc_top.sv
// Purpose: digital model of a PLL clock conditioning circuit
// Assumes: all pins synchronous to clk_sys; VCO model ticks at most once per clock
// Notes: analog delays are reported in ps, not applied
// Contract
// - Input and feedback dividers, factor 1..128
// - Three output dividers, factor 1..32
// - Output freq = ref*m/(n*div); fabric equals global
// - Lock high after 4 reference edges with a stable period
// - 2 ns system delay, 0.6-5.56 ns feedback
// - System and feedback delay bypass independently
// - Feedback delay advances outputs
// - Global delay 0.025, 0.76..5.56 ns, +0.755
// - Fabric outputs delay 0.6..5.56 ns
// - Per-path phase 0/90/180/270 degrees
// - Phase applied before divider and delay
// - Serial shift configuration ports, dynamic reconfig
// - Three clock inputs, each independently selected
// - Static mode uses nonvolatile default bits
// - Nonvolatile bits fixed, no run-time path
// - Source select high picks the update register, loaded from the shift register on update strobe
`timescale 1ns/1ps
`default_nettype none
module pllcc_top
  import pllcc_pkg::*;
#(
  parameter int DIV_IN_MAX = 128,
  parameter int DIV_OUT_MAX = 32,
  parameter logic [CFG_W-1:0] STATIC_CFG = STATIC_CFG_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reference_clock_in,
  input wire logic second_clock_in,
  input wire logic third_clock_in,
  input wire logic config_source_dynamic,
  input wire logic config_serial_in,
  input wire logic config_shift_enable,
  input wire logic config_update_strobe,
  output logic config_serial_out,
  output logic primary_global_out,
  output logic secondary1_global_out,
  output logic secondary2_global_out,
  output logic secondary1_fabric_out,
  output logic secondary2_fabric_out,
  output logic lock_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (DIV_IN_MAX != 128 || DIV_OUT_MAX != 32) begin : g_chk
    $error("pllcc_top: divider ranges are fixed by field widths");
  end

  function automatic logic [15:0] gl_ps(input logic [4:0] c);
    logic [15:0] r;
    r = (c == 5'h00) ? 16'(GL_FIRST_PS) : 16'(GL_SECOND_PS + STEP_PS * (int'(c) - 1));
    return 16'(r + 16'(GL_DRIVER_PS));
  endfunction : gl_ps

  function automatic logic [15:0] fine_ps(input logic [4:0] c);
    return 16'(FINE_BASE_PS + STEP_PS * int'(c));
  endfunction : fine_ps

  ////////////////////////////////////////////////////////////////////////
  // Configuration source
  logic [CFG_W-1:0] shift_r;
  logic [CFG_W-1:0] dyn_r;
  logic [CFG_W-1:0] cfg;
  logic cfg_src_r;
  logic update_evt;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= '0;
    end else if (config_shift_enable) begin
      shift_r <= {config_serial_in, shift_r[CFG_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dyn_r <= STATIC_CFG;
    end else if (config_update_strobe && !config_shift_enable) begin
      dyn_r <= shift_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      config_serial_out <= 1'b0;
      cfg_src_r <= 1'b0;
    end else begin
      config_serial_out <= shift_r[0];
      cfg_src_r <= config_source_dynamic;
    end
  end

  assign update_evt = (config_update_strobe && !config_shift_enable && cfg_src_r)
                      || (cfg_src_r != config_source_dynamic);
  // Static bits are a parameter only, nothing writes them
  assign cfg = cfg_src_r ? dyn_r : STATIC_CFG;

  logic [7:0] div_n;
  logic [7:0] div_m;
  assign div_n = {1'b0, cfg[F_N +: 7]} + 8'h01;
  assign div_m = {1'b0, cfg[F_M +: 7]} + 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // Reference period measurement
  logic ref_d_r;
  logic ref_rise;
  logic [11:0] ref_cnt_r;
  logic [11:0] ref_per_r;
  logic ref_absent_r;
  logic per_stable;

  assign ref_rise = reference_clock_in && !ref_d_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ref_d_r <= 1'b0;
      ref_cnt_r <= '0;
      ref_per_r <= '0;
      ref_absent_r <= 1'b1;
    end else begin
      ref_d_r <= reference_clock_in;
      if (ref_rise) begin
        ref_cnt_r <= 12'h001;
        ref_per_r <= ref_cnt_r;
        ref_absent_r <= 1'b0;
      end else if (ref_cnt_r == 12'(REF_TIMEOUT_CYC)) begin
        ref_absent_r <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r + 12'h001;
      end
    end
  end

  assign per_stable = (ref_cnt_r == ref_per_r) || (ref_cnt_r == ref_per_r + 12'h001)
                      || (ref_cnt_r + 12'h001 == ref_per_r);

  ////////////////////////////////////////////////////////////////////////
  // VCO model: four ticks per VCO period, aligned every n-th reference edge
  logic [19:0] lim_r;
  logic [19:0] acc_r;
  logic [19:0] acc_sum;
  logic [6:0] nref_r;
  logic [1:0] quad_r;
  logic vco_tick;

  assign acc_sum = acc_r + {10'h000, div_m, 2'b00};
  assign vco_tick = (acc_sum >= lim_r) && (lim_r != 20'h00000);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lim_r <= '0;
      acc_r <= '0;
      nref_r <= '0;
      quad_r <= '0;
    end else begin
      lim_r <= 20'(ref_per_r) * 20'(div_n);
      if (ref_rise && nref_r == 7'(div_n - 8'h01)) begin
        nref_r <= '0;
        acc_r <= '0;
        quad_r <= '0;
      end else begin
        if (ref_rise) begin
          nref_r <= nref_r + 7'h01;
        end
        if (vco_tick) begin
          acc_r <= acc_sum - lim_r;
          quad_r <= quad_r + 2'h1;
        end else begin
          acc_r <= acc_sum;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output paths: source select, phase, divider
  logic [2:0] raw_in;
  logic [2:0] path_out_r;
  logic [4:0] out_dly [3];
  assign raw_in = {third_clock_in, second_clock_in, reference_clock_in};
  assign out_dly[0] = cfg[F_DLY_A +: 5];
  assign out_dly[1] = cfg[F_DLY_B +: 5];
  assign out_dly[2] = cfg[F_DLY_C +: 5];

  for (genvar p = 0; p < 3; p++) begin : g_path
    logic [1:0] ph;
    logic [5:0] div;
    logic phase_clk;
    logic src;
    logic src_d_r;
    logic [5:0] cnt_r;
    assign ph = cfg[F_PH_A + 2 * p +: 2];
    assign div = {1'b0, cfg[F_U + 5 * p +: 5]} + 6'h01;
    assign phase_clk = 2'(quad_r - ph) >= 2'h2;
    assign src = cfg[F_SRC_A + p] ? raw_in[p] : phase_clk;
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        src_d_r <= 1'b0;
        cnt_r <= '0;
        path_out_r[p] <= 1'b0;
      end else begin
        src_d_r <= src;
        if (src && !src_d_r) begin
          cnt_r <= (cnt_r + 6'h01 >= div) ? 6'h00 : cnt_r + 6'h01;
        end
        path_out_r[p] <= (div == 6'h01) ? src : (cnt_r < {1'b0, div[5:1]});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock state
  pllcc_lock_t lk_r;
  logic [2:0] lk_cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lk_r <= PLLCC_LK_IDLE;
      lk_cnt_r <= '0;
    end else if (ref_absent_r || update_evt) begin
      lk_r <= PLLCC_LK_IDLE;
      lk_cnt_r <= '0;
    end else if (ref_rise) begin
      case (lk_r)
        PLLCC_LK_IDLE: begin
          lk_r <= PLLCC_LK_ACQ;
          lk_cnt_r <= '0;
        end
        PLLCC_LK_ACQ: begin
          if (!per_stable) begin
            lk_cnt_r <= '0;
          end else if (lk_cnt_r == 3'(LOCK_EDGES - 1)) begin
            lk_r <= PLLCC_LK_LOCKED;
          end else begin
            lk_cnt_r <= lk_cnt_r + 3'h1;
          end
        end
        PLLCC_LK_LOCKED: begin
          if (!per_stable) begin
            lk_r <= PLLCC_LK_ACQ;
            lk_cnt_r <= '0;
          end
        end
        default: lk_r <= PLLCC_LK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output flops
  logic [31:0] ctrl_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      primary_global_out <= 1'b0;
      secondary1_global_out <= 1'b0;
      secondary2_global_out <= 1'b0;
      secondary1_fabric_out <= 1'b0;
      secondary2_fabric_out <= 1'b0;
      lock_out <= 1'b0;
    end else begin
      primary_global_out <= path_out_r[0] && ctrl_r[0];
      secondary1_global_out <= path_out_r[1] && ctrl_r[0];
      secondary2_global_out <= path_out_r[2] && ctrl_r[0];
      secondary1_fabric_out <= path_out_r[1] && ctrl_r[0];
      secondary2_fabric_out <= path_out_r[2] && ctrl_r[0];
      lock_out <= (lk_r == PLLCC_LK_LOCKED);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delay report
  logic [15:0] advance_ps;
  logic [15:0] dly_ps [5];
  logic [7:0] dly_ofs;
  always_comb begin
    advance_ps = 16'h0000;
    if (cfg[F_SYS_EN]) begin
      advance_ps = 16'(SYS_DLY_PS);
    end
    if (cfg[F_FB_EN]) begin
      advance_ps = advance_ps + fine_ps(cfg[F_FBDLY +: 5]);
    end
  end
  for (genvar d = 0; d < 3; d++) begin : g_gldly
    assign dly_ps[d] = gl_ps(out_dly[d]);
  end
  assign dly_ps[3] = fine_ps(cfg[F_DLY_YB +: 5]);
  assign dly_ps[4] = fine_ps(cfg[F_DLY_YC +: 5]);
  // Byte offset from the first delay register
  assign dly_ofs = s_axi_araddr - OFS_DLY0;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic [31:0] rd_val;
  logic rd_ok;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_r <= CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[7:2] == OFS_CTRL[7:2]) begin
          s_axi_bresp <= 2'b00;
          for (int b = 0; b < 4; b++) begin
            if (wstrb_r[b]) begin
              ctrl_r[8*b +: 8] <= {7'h00, b == 0 && wdata_r[0]};
            end
          end
        end else begin
          s_axi_bresp <= (awaddr_r <= OFS_CFG0 + 8'h08) ? 2'b00 : 2'b10;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] == OFS_CTRL[7:2]) begin
      rd_val = ctrl_r;
    end else if (s_axi_araddr[7:2] == OFS_STATUS[7:2]) begin
      rd_val = {28'h0000000, cfg_src_r, ref_absent_r, lk_r};
    end else if (s_axi_araddr[7:2] == OFS_REF_PER[7:2]) begin
      rd_val = {20'h00000, ref_per_r};
    end else if (s_axi_araddr[7:2] == OFS_ADVANCE[7:2]) begin
      rd_val = {16'h0000, advance_ps};
    end else if (s_axi_araddr >= OFS_DLY0 && s_axi_araddr < OFS_CFG0) begin
      rd_val = {16'h0000, dly_ps[dly_ofs[4:2]]};
    end else if (s_axi_araddr[7:2] == OFS_CFG0[7:2]) begin
      rd_val = cfg[31:0];
    end else if (s_axi_araddr[7:2] == OFS_CFG0[7:2] + 6'h01) begin
      rd_val = cfg[63:32];
    end else if (s_axi_araddr[7:2] == OFS_CFG0[7:2] + 6'h02) begin
      rd_val = {15'h0000, cfg[80:64]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : pllcc_top
`default_nettype wire

// ===== shared/pllcc_pkg.sv
// Purpose: constants for the clock conditioning model
// Assumes: one 40 MHz system clock
// Notes: field layout of the 81-bit configuration word
`default_nettype none
package pllcc_pkg;
  localparam int CFG_W = 81;
  // Configuration field positions
  localparam int F_N = 0;
  localparam int F_M = 7;
  localparam int F_U = 14;
  localparam int F_V = 19;
  localparam int F_W = 24;
  localparam int F_FBDLY = 29;
  localparam int F_SYS_EN = 34;
  localparam int F_FB_EN = 35;
  localparam int F_DLY_A = 36;
  localparam int F_DLY_B = 41;
  localparam int F_DLY_C = 46;
  localparam int F_DLY_YB = 51;
  localparam int F_DLY_YC = 56;
  localparam int F_PH_A = 61;
  localparam int F_SRC_A = 67;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_REF_PER = 8'h08;
  localparam logic [7:0] OFS_ADVANCE = 8'h0C;
  localparam logic [7:0] OFS_DLY0 = 8'h10;
  localparam logic [7:0] OFS_CFG0 = 8'h24;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [CFG_W-1:0] STATIC_CFG_DEF = 81'h0_0000_0000_0000_0000_0180;
  // Delay figures in ps
  localparam int SYS_DLY_PS = 2000;
  localparam int STEP_PS = 160;
  localparam int FINE_BASE_PS = 600;
  localparam int GL_FIRST_PS = 25;
  localparam int GL_SECOND_PS = 760;
  localparam int GL_DRIVER_PS = 755;
  // Timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int REF_TIMEOUT_NS = 100000;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int LOCK_EDGES = 4;
  typedef enum logic [1:0] {
    PLLCC_LK_IDLE = 2'b00,
    PLLCC_LK_ACQ = 2'b01,
    PLLCC_LK_LOCKED = 2'b11
  } pllcc_lock_t;
endpackage : pllcc_pkg
`default_nettype wire

// ===== tb/pllcc_checker.sv
// Purpose: port assertions for pllcc_top
// Assumes: one clk_sys domain
// Notes: bound to every pllcc_top below
`timescale 1ns/1ps
`default_nettype none
module pllcc_checker
  import pllcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reference_clock_in,
  input wire logic config_source_dynamic,
  input wire logic config_shift_enable,
  input wire logic config_update_strobe,
  input wire logic secondary1_global_out,
  input wire logic secondary2_global_out,
  input wire logic secondary1_fabric_out,
  input wire logic secondary2_fabric_out,
  input wire logic lock_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] quiet_r;
  logic ref_d_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      quiet_r <= 16'h0000;
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= reference_clock_in;
      if (reference_clock_in != ref_d_r) quiet_r <= 16'h0000;
      else if (quiet_r != 16'hFFFF) quiet_r <= quiet_r + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_fab1;
    secondary1_fabric_out == secondary1_global_out;
  endproperty
  a_fab1: assert property (p_fab1) else $error("fabric 1 differs from global 1");
  property p_fab2;
    secondary2_fabric_out == secondary2_global_out;
  endproperty
  a_fab2: assert property (p_fab2) else $error("fabric 2 differs from global 2");
  property p_upd;
    config_update_strobe && !config_shift_enable && config_source_dynamic |-> ##[1:3] !lock_out;
  endproperty
  a_upd: assert property (p_upd) else $error("lock held over update");
  property p_src;
    $changed(config_source_dynamic) |-> ##[1:4] !lock_out;
  endproperty
  a_src: assert property (p_src) else $error("lock held over source change");
  property p_absent;
    quiet_r > 16'(REF_TIMEOUT_CYC + 8) |-> !lock_out;
  endproperty
  a_absent: assert property (p_absent) else $error("lock with no reference");
  property p_lockref;
    $rose(lock_out) |-> quiet_r < 16'h0040;
  endproperty
  a_lockref: assert property (p_lockref) else $error("lock rose on idle reference");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  c_lock: cover property ($rose(lock_out));
  c_upd: cover property (config_update_strobe);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule : pllcc_checker
bind pllcc_top pllcc_checker u_pllcc_checker (
  .clk_sys, .reset_n, .reference_clock_in, .config_source_dynamic, .config_shift_enable,
  .config_update_strobe, .secondary1_global_out, .secondary2_global_out,
  .secondary1_fabric_out, .secondary2_fabric_out, .lock_out, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ===== tb/pllcc_ref_src.sv
// Purpose: reference and spare clock source
// Assumes: periods in whole clk_sys cycles
// Notes: clocks stand still while stopped
`timescale 1ns/1ps
`default_nettype none
module pllcc_ref_src (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [7:0] half_cyc,
  output logic reference_clock_in,
  output logic second_clock_in,
  output logic third_clock_in
);
  logic [7:0] cnt_r = 8'h00;
  logic [2:0] div_r = 3'h0;
  always_ff @(posedge clk_sys) begin
    if (run) begin
      if (cnt_r == half_cyc - 8'h01) begin
        cnt_r <= 8'h00;
        div_r <= div_r + 3'h1;
      end else cnt_r <= cnt_r + 8'h01;
    end
  end
  assign reference_clock_in = div_r[0];
  assign second_clock_in = div_r[1];
  assign third_clock_in = div_r[2];
endmodule : pllcc_ref_src
`default_nettype wire

// ===== tb/pllcc_tb_top.sv
// Purpose: self-checking bench for pllcc_top
// Assumes: reference period 16 clk_sys cycles
// Notes: frequencies checked by edge counts
`timescale 1ns/1ps
`default_nettype none
module pllcc_tb_top
  import pllcc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n, ref_run, config_source_dynamic, config_serial_in;
  logic config_shift_enable, config_update_strobe;
  logic [7:0] ref_half, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0] s_axi_wstrb;
  wire logic reference_clock_in, second_clock_in, third_clock_in, config_serial_out, lock_out;
  wire logic primary_global_out, secondary1_global_out, secondary2_global_out;
  wire logic secondary1_fabric_out, secondary2_fabric_out, s_axi_awready, s_axi_wready;
  wire logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  logic [1:0] rsp;
  logic [80:0] cfg_a, cfg_b;
  int fails = 0;
  int total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  pllcc_ref_src u_pllcc_ref_src (.clk_sys, .run(ref_run), .half_cyc(ref_half),
    .reference_clock_in, .second_clock_in, .third_clock_in);
  pllcc_top u_pllcc_top (.clk_sys, .reset_n, .reference_clock_in, .second_clock_in,
    .third_clock_in, .config_source_dynamic, .config_serial_in, .config_shift_enable,
    .config_update_strobe, .config_serial_out, .primary_global_out, .secondary1_global_out,
    .secondary2_global_out, .secondary1_fabric_out, .secondary2_fabric_out, .lock_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    check(rd, e);
  endtask : rd_chk
  task automatic load_cfg(input logic [80:0] w);
    for (int i = 0; i < CFG_W; i++) begin
      @(posedge clk_sys);
      config_shift_enable <= 1'b1;
      config_serial_in <= w[i];
    end
    @(posedge clk_sys);
    config_shift_enable <= 1'b0;
    config_serial_in <= ~w[80];
    config_update_strobe <= 1'b1;
    @(posedge clk_sys);
    config_update_strobe <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check(32'(lock_out), 32'h0);
    check(32'(config_serial_out), 32'(w[0]));
  endtask : load_cfg
  task automatic wait_lock;
    for (int n = 0; n < 2000 && !lock_out; n++) @(posedge clk_sys);
    check(32'(lock_out), 32'h1);
  endtask : wait_lock
  task automatic fchk(input int sel, input int e);
    int c;
    logic p;
    logic v;
    c = 0;
    p = 1'b1;
    repeat (320) begin
      @(posedge clk_sys);
      v = sel == 0 ? primary_global_out : sel == 1 ? secondary1_global_out : secondary2_global_out;
      if (v && !p) c++;
      p = v;
    end
    check(32'((c >= e - 1) && (c <= e + 1)), 32'h1);
  endtask : fchk
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    {ref_run, config_source_dynamic, config_serial_in, config_shift_enable} = 4'h0;
    {config_update_strobe, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    ref_half = 8'h08;
    cfg_a = '0;
    cfg_a[F_M +: 7] = 7'h01;
    cfg_a[F_V +: 5] = 5'h01;
    cfg_a[F_W +: 5] = 5'h03;
    cfg_a[F_FBDLY +: 5] = 5'h03;
    cfg_a[F_SYS_EN +: 2] = 2'h3;
    cfg_a[F_DLY_A +: 5] = 5'h02;
    cfg_a[F_DLY_YB +: 5] = 5'h04;
    cfg_b = '0;
    cfg_b[F_N +: 7] = 7'h01;
    cfg_b[F_M +: 7] = 7'h07;
    cfg_b[F_FBDLY +: 5] = 5'h03;
    cfg_b[F_FB_EN] = 1'b1;
    cfg_b[F_PH_A +: 2] = 2'h2;
    cfg_b[F_SRC_A + 1] = 1'b1;
    cfg_b[F_DLY_A +: 5] = 5'h1F;
    cfg_b[F_DLY_YC +: 5] = 5'h1F;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(OFS_CTRL, CTRL_RST);
    rd_chk(OFS_CFG0, STATIC_CFG_DEF[31:0]);
    rd_chk(8'h28, STATIC_CFG_DEF[63:32]);
    rd_chk(8'h40, 32'h0);
    check(32'(rsp), 32'h2);
    axi_wr(8'h30, 32'h0);
    check(32'(rsp), 32'h2);
    axi_wr(OFS_CFG0, 32'hFFFF_FFFF);
    check(32'(rsp), 32'h0);
    rd_chk(OFS_CFG0, STATIC_CFG_DEF[31:0]);
    ref_run <= 1'b1;
    wait_lock;
    rd_chk(OFS_STATUS, 32'h0000_0003);
    rd_chk(OFS_REF_PER, 32'h0000_0010);
    for (int s = 0; s < 3; s++) fchk(s, 80);
    axi_wr(OFS_CTRL, 32'h0);
    fchk(0, 0);
    axi_wr(OFS_CTRL, 32'h1);
    config_source_dynamic <= 1'b1;
    load_cfg(cfg_a);
    wait_lock;
    rd_chk(OFS_STATUS, 32'h0000_000B);
    rd_chk(OFS_CFG0, cfg_a[31:0]);
    rd_chk(8'h2C, {15'h0000, cfg_a[80:64]});
    rd_chk(OFS_ADVANCE, 32'h0000_0C08);
    rd_chk(OFS_DLY0, 32'h0000_068B);
    rd_chk(8'h14, 32'h0000_030C);
    rd_chk(8'h1C, 32'h0000_04D8);
    fchk(0, 40);
    fchk(1, 20);
    fchk(2, 10);
    load_cfg(cfg_b);
    wait_lock;
    rd_chk(OFS_ADVANCE, 32'h0000_0438);
    rd_chk(OFS_DLY0, 32'h0000_18AB);
    rd_chk(8'h20, 32'h0000_15B8);
    fchk(0, 80);
    fchk(1, 10);
    repeat (6) begin
      @(posedge clk_sys);
      check(32'(primary_global_out ^ secondary2_global_out), 32'h1);
    end
    config_source_dynamic <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wait_lock;
    rd_chk(OFS_CFG0, STATIC_CFG_DEF[31:0]);
    ref_run <= 1'b0;
    repeat (REF_TIMEOUT_CYC + 20) @(posedge clk_sys);
    check(32'(lock_out), 32'h0);
    axi_rd(OFS_STATUS);
    check(32'(rd[2]), 32'h1);
    results;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    results;
  end
endmodule : pllcc_tb_top
`default_nettype wire
